// ### rtl/rtcw_defs.svh
// Constants for the two-wire clock register access block
`ifndef RTCW_DEFS_SVH
`define RTCW_DEFS_SVH
`define RTCW_SLAVE_ADDR_BYTE 8'hD0
`define RTCW_NUM_REGS 8
`define RTCW_ADDR_SECONDS 3'h0
`define RTCW_ADDR_MINUTES 3'h1
`define RTCW_ADDR_HOURS 3'h2
`define RTCW_ADDR_WEEKDAY 3'h3
`define RTCW_ADDR_MDAY 3'h4
`define RTCW_ADDR_CMONTH 3'h5
`define RTCW_ADDR_YEAR 3'h6
`define RTCW_ADDR_TRIM 3'h7
`define RTCW_LAST_CLOCK_ADDR 3'h6
`define RTCW_OSC_HALT_BIT 7
`define RTCW_OSC_FAIL_IRQ_EN_BIT 7
`define RTCW_CENTURY_LOW_BIT 6
`define RTCW_CENTURY_HIGH_BIT 7
`define RTCW_WEEKDAY_MSB 2
`define RTCW_CLK_PERIOD_NS 100
`define RTCW_DIV_TICK_NS 100000
`define RTCW_DIV_TICK_CYC (`RTCW_DIV_TICK_NS / `RTCW_CLK_PERIOD_NS)
`endif

// ### rtl/rtcw_pkg.sv
// Types for the two-wire clock register access block
package rtcw_pkg;
  typedef enum logic [2:0] {
    RTCW_IDLE, RTCW_DEV_ADDR, RTCW_ADDR_ACK, RTCW_WORD_ADDR,
    RTCW_WRITE_DATA, RTCW_READ_DATA, RTCW_MASTER_ACK
  } rtcw_phase_e;
  typedef struct packed {
    logic scl;
    logic sda;
  } rtcw_bus_s;
  typedef struct packed {
    logic start;
    logic stop;
    logic scl_rise;
    logic scl_fall;
    logic sda;
  } rtcw_events_s;
endpackage : rtcw_pkg

// ### rtl/rtcw_line_sync.sv
// Pin synchroniser and START/STOP/edge detector for the two bus lines
`timescale 1ns/10ps
`include "rtcw_defs.svh"
module rtcw_line_sync
  import rtcw_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic scl_in,
  input wire logic sda_in,
  output rtcw_events_s ev
);
  typedef struct packed {
    rtcw_bus_s meta;
    rtcw_bus_s sync;
    rtcw_bus_s prev;
    rtcw_events_s ev;
  } rtcw_sync_state_s;
  rtcw_sync_state_s s_q;
  rtcw_sync_state_s s_d;
  always_comb begin
    s_d = s_q;
    s_d.meta.scl = scl_in;
    s_d.meta.sda = sda_in;
    s_d.sync = s_q.meta;
    s_d.prev = s_q.sync;
    // Line changes while the clock is high are control conditions
    s_d.ev.start = s_q.prev.scl && s_q.sync.scl &&
                   s_q.prev.sda && !s_q.sync.sda;
    s_d.ev.stop = s_q.prev.scl && s_q.sync.scl &&
                  !s_q.prev.sda && s_q.sync.sda;
    s_d.ev.scl_rise = !s_q.prev.scl && s_q.sync.scl;
    s_d.ev.scl_fall = s_q.prev.scl && !s_q.sync.scl;
    s_d.ev.sda = s_q.sync.sda;
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= '{meta: 2'h3, sync: 2'h3, prev: 2'h3, ev: 5'h01};
    end else begin
      s_q <= s_d;
    end
  end
  assign ev = s_q.ev;
endmodule : rtcw_line_sync

// ### rtl/rtcw_slave.sv
// Two-wire slave giving byte access to the eight clock registers
// Operation
// - Respond only to START plus fixed address
// - Eight registers in seconds-to-calibration order
// - Data falling while clock high is START
// - Data rising while clock high is STOP
// - Data changes only while clock low
// - Eight-bit bytes, each with ninth acknowledge
// - Acknowledge every received byte when addressed
// - Master nack ends read; release data
// - Acknowledge low through the clock high phase
// - Read pointer advances only on master acknowledge
// - Keep sending consecutive bytes until master nack
// - Freeze time copy while clock addresses read
// - Plain read starts at held pointer
// - Write loads pointer, stores data, increments
// - Bank holds BCD time, shared set/read
// - Century bits in month register D6/D7
// - Weekday in three low day bits
// - Halt bit stops oscillator; clear restarts
// - Minutes MSB is fail interrupt enable
// - Clock register write reloads, resets divider
`timescale 1ns/10ps
`include "rtcw_defs.svh"
module rtcw_slave
  import rtcw_pkg::*;
#(
  parameter int NUM_REGS = `RTCW_NUM_REGS,
  parameter int DIV_TICK_CYC = `RTCW_DIV_TICK_CYC
)(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Live time from the counter chain, copied in when not frozen
  input wire logic [55:0] live_time,
  output logic [55:0] load_time,
  output logic load_strobe,
  output logic div_reset,
  output logic osc_halt_bit,
  output logic osc_fail_irq_enable,
  output logic [7:0] rate_trim,
  output logic update_frozen,
  output logic div_tick
);
  // The divider counter is sixteen bits wide
  if (NUM_REGS != 8) begin : g_bad_regs
    $error("rtcw_slave serves exactly eight registers");
  end
  if (DIV_TICK_CYC < 1 || DIV_TICK_CYC > 65536) begin : g_bad_div
    $error("rtcw_slave divider count out of range");
  end

  // ********************
  // State
  // ********************
  typedef struct packed {
    rtcw_phase_e phase;
    logic [3:0] bit_cnt;
    logic [7:0] shreg;
    logic rd_mode;
    logic [2:0] ptr;
    logic [7:0][7:0] regs;
    logic frozen;
    logic sda_oe;
    logic ack_nack;
    logic load_strobe;
    logic div_reset;
    logic [15:0] div_cnt;
    logic div_tick;
  } rtcw_state_s;
  rtcw_state_s s_q;
  rtcw_state_s s_d;
  rtcw_events_s ev;
  localparam logic [6:0] OWN_ADDR = 7'(`RTCW_SLAVE_ADDR_BYTE >> 1);

  rtcw_line_sync u_sync (
    .clk(clk),
    .arst_n(arst_n),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .ev(ev)
  );

  function automatic logic [2:0] next_ptr(input logic [2:0] p);
    next_ptr = (p == `RTCW_ADDR_TRIM) ? `RTCW_ADDR_SECONDS : p + 3'h1;
  endfunction : next_ptr

  function automatic logic is_clock_addr(input logic [2:0] p);
    is_clock_addr = (p <= `RTCW_LAST_CLOCK_ADDR);
  endfunction : is_clock_addr

  // ********************
  // Protocol engine
  // ********************
  always_comb begin
    s_d = s_q;
    s_d.load_strobe = 1'b0;
    s_d.div_reset = 1'b0;
    s_d.div_tick = 1'b0;
    if (s_q.div_reset || s_q.regs[0][`RTCW_OSC_HALT_BIT]) begin
      s_d.div_cnt = 16'h0000;
    end else if (s_q.div_cnt == 16'(DIV_TICK_CYC - 1)) begin
      s_d.div_cnt = 16'h0000;
      s_d.div_tick = 1'b1;
    end else begin
      s_d.div_cnt = s_q.div_cnt + 16'h0001;
    end
    if (!s_q.frozen) begin
      // Snapshot the seven time registers; control bits stay as written
      for (int i = 0; i < 7; i++) begin
        s_d.regs[i] = live_time[i*8 +: 8];
      end
      s_d.regs[0][`RTCW_OSC_HALT_BIT] = s_q.regs[0][`RTCW_OSC_HALT_BIT];
      s_d.regs[1][`RTCW_OSC_FAIL_IRQ_EN_BIT] =
        s_q.regs[1][`RTCW_OSC_FAIL_IRQ_EN_BIT];
    end
    if (ev.start) begin
      s_d.phase = RTCW_DEV_ADDR;
      s_d.bit_cnt = 4'h0;
      s_d.sda_oe = 1'b0;
      s_d.frozen = 1'b0;
    end else if (ev.stop) begin
      s_d.phase = RTCW_IDLE;
      s_d.sda_oe = 1'b0;
      s_d.frozen = 1'b0;
    end else if (ev.scl_rise) begin
      unique case (s_q.phase)
        RTCW_DEV_ADDR, RTCW_WORD_ADDR, RTCW_WRITE_DATA: begin
          if (s_q.bit_cnt < 4'h8) begin
            s_d.shreg = {s_q.shreg[6:0], ev.sda};
            s_d.bit_cnt = s_q.bit_cnt + 4'h1;
          end
        end
        RTCW_READ_DATA: begin
          if (s_q.bit_cnt == 4'h8) begin
            s_d.ack_nack = ev.sda;
          end
        end
        default: begin
        end
      endcase
    end else if (ev.scl_fall) begin
      unique case (s_q.phase)
        RTCW_IDLE: begin
        end
        RTCW_DEV_ADDR: begin
          if (s_q.bit_cnt == 4'h8) begin
            if (s_q.shreg[7:1] == OWN_ADDR) begin
              s_d.sda_oe = 1'b1;
              s_d.rd_mode = s_q.shreg[0];
              s_d.bit_cnt = 4'h9;
            end else begin
              s_d.phase = RTCW_IDLE;
            end
          end else if (s_q.bit_cnt == 4'h9) begin
            s_d.sda_oe = 1'b0;
            s_d.bit_cnt = 4'h0;
            if (s_q.rd_mode) begin
              s_d.phase = RTCW_READ_DATA;
              s_d.shreg = s_q.regs[s_q.ptr];
              s_d.frozen = is_clock_addr(s_q.ptr);
              s_d.sda_oe = !s_q.regs[s_q.ptr][7];
            end else begin
              s_d.phase = RTCW_WORD_ADDR;
            end
          end
        end
        RTCW_WORD_ADDR, RTCW_WRITE_DATA: begin
          if (s_q.bit_cnt == 4'h8) begin
            s_d.sda_oe = 1'b1;
            s_d.bit_cnt = 4'h9;
            if (s_q.phase == RTCW_WORD_ADDR) begin
              s_d.ptr = s_q.shreg[2:0];
            end else begin
              s_d.regs[s_q.ptr] = s_q.shreg;
              if (is_clock_addr(s_q.ptr)) begin
                s_d.load_strobe = 1'b1;
                s_d.div_reset = 1'b1;
              end
            end
          end else if (s_q.bit_cnt == 4'h9) begin
            s_d.sda_oe = 1'b0;
            s_d.bit_cnt = 4'h0;
            if (s_q.phase == RTCW_WRITE_DATA) begin
              s_d.ptr = next_ptr(s_q.ptr);
            end
            s_d.phase = RTCW_WRITE_DATA;
          end
        end
        RTCW_READ_DATA: begin
          if (s_q.bit_cnt < 4'h7) begin
            s_d.shreg = {s_q.shreg[6:0], 1'b0};
            s_d.sda_oe = !s_q.shreg[6];
            s_d.bit_cnt = s_q.bit_cnt + 4'h1;
          end else if (s_q.bit_cnt == 4'h7) begin
            s_d.sda_oe = 1'b0;
            s_d.bit_cnt = 4'h8;
          end else begin
            s_d.bit_cnt = 4'h0;
            if (!s_q.ack_nack) begin
              s_d.ptr = next_ptr(s_q.ptr);
              s_d.shreg = s_q.regs[next_ptr(s_q.ptr)];
              s_d.sda_oe = !s_q.regs[next_ptr(s_q.ptr)][7];
              s_d.frozen = is_clock_addr(next_ptr(s_q.ptr));
            end else begin
              s_d.phase = RTCW_MASTER_ACK;
              s_d.sda_oe = 1'b0;
            end
          end
        end
        RTCW_MASTER_ACK: begin
          s_d.sda_oe = 1'b0;
        end
        default: begin
          s_d.phase = RTCW_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= '{phase: RTCW_IDLE, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  // ********************
  // Outputs
  // ********************
  assign sda_out = 1'b0;
  assign sda_oe = s_q.sda_oe;
  assign load_time = {s_q.regs[6], s_q.regs[5], s_q.regs[4], s_q.regs[3],
                      s_q.regs[2], s_q.regs[1], s_q.regs[0]};
  assign load_strobe = s_q.load_strobe;
  assign div_reset = s_q.div_reset;
  assign osc_halt_bit = s_q.regs[0][`RTCW_OSC_HALT_BIT];
  assign osc_fail_irq_enable = s_q.regs[1][`RTCW_OSC_FAIL_IRQ_EN_BIT];
  assign rate_trim = s_q.regs[7];
  assign update_frozen = s_q.frozen;
  assign div_tick = s_q.div_tick;

  // ********************
  // Checks
  // ********************
  property p_nack_foreign;
    @(posedge clk) disable iff (!arst_n)
      (ev.scl_fall && s_q.phase == RTCW_DEV_ADDR && s_q.bit_cnt == 4'h8 &&
       s_q.shreg[7:1] != 7'h68 && !ev.start && !ev.stop) |=> !s_q.sda_oe;
  endproperty
  a_nack_foreign: assert property (p_nack_foreign)
    else $error("acknowledged a foreign address");
  property p_ack_own;
    @(posedge clk) disable iff (!arst_n)
      (ev.scl_fall && s_q.phase == RTCW_DEV_ADDR && s_q.bit_cnt == 4'h8 &&
       s_q.shreg[7:1] == 7'h68 && !ev.start && !ev.stop) |=> s_q.sda_oe;
  endproperty
  a_ack_own: assert property (p_ack_own)
    else $error("own address not acknowledged");
  property p_stop_idle;
    @(posedge clk) disable iff (!arst_n)
      (ev.stop && !ev.start) |=> s_q.phase == RTCW_IDLE && !s_q.frozen;
  endproperty
  a_stop_idle: assert property (p_stop_idle)
    else $error("stop did not end transfer");
  property p_start_addr;
    @(posedge clk) disable iff (!arst_n)
      ev.start |=> s_q.phase == RTCW_DEV_ADDR && s_q.bit_cnt == 4'h0;
  endproperty
  a_start_addr: assert property (p_start_addr)
    else $error("start not recognised");
  property p_oe_stable_high;
    @(posedge clk) disable iff (!arst_n)
      (ev.scl_rise ##1 !ev.scl_fall && !ev.start && !ev.stop)
        |-> $stable(s_q.sda_oe);
  endproperty
  a_oe_stable_high: assert property (p_oe_stable_high)
    else $error("data changed while clock high");
  property p_read_nack_release;
    @(posedge clk) disable iff (!arst_n)
      (s_q.phase == RTCW_READ_DATA && s_q.bit_cnt == 4'h8) |-> !s_q.sda_oe;
  endproperty
  a_read_nack_release: assert property (p_read_nack_release)
    else $error("data not released for master acknowledge");
  property p_ptr_hold_read;
    @(posedge clk) disable iff (!arst_n)
      (s_q.phase == RTCW_READ_DATA && s_q.bit_cnt != 4'h8 && !ev.start)
        |=> $stable(s_q.ptr);
  endproperty
  a_ptr_hold_read: assert property (p_ptr_hold_read)
    else $error("pointer moved without acknowledge");
  property p_write_load;
    @(posedge clk) disable iff (!arst_n)
      s_q.load_strobe |-> s_q.div_reset ##1 s_q.div_cnt == 16'h0000;
  endproperty
  a_write_load: assert property (p_write_load)
    else $error("divider not reset on clock write");
  property p_frozen_clock;
    @(posedge clk) disable iff (!arst_n)
      (s_q.frozen && !ev.start && !ev.stop && s_q.phase == RTCW_READ_DATA)
        |=> $stable(s_q.regs[0][6:0]);
  endproperty
  a_frozen_clock: assert property (p_frozen_clock)
    else $error("time copy changed while frozen");
  property p_copy_fields;
    @(posedge clk) disable iff (!arst_n)
      !s_q.frozen |=> s_q.load_strobe ||
        (s_q.regs[3][`RTCW_WEEKDAY_MSB:0] == $past(live_time[26:24]) &&
         s_q.regs[5][`RTCW_CENTURY_HIGH_BIT:`RTCW_CENTURY_LOW_BIT] ==
           $past(live_time[47:46]));
  endproperty
  a_copy_fields: assert property (p_copy_fields)
    else $error("calendar fields not copied");
  property p_data_ack;
    @(posedge clk) disable iff (!arst_n)
      (ev.scl_fall && s_q.phase == RTCW_WRITE_DATA && s_q.bit_cnt == 4'h8 &&
       !ev.start && !ev.stop) |=> s_q.sda_oe && s_q.bit_cnt == 4'h9;
  endproperty
  a_data_ack: assert property (p_data_ack)
    else $error("data byte not acknowledged");
  property p_write_ptr;
    @(posedge clk) disable iff (!arst_n)
      (ev.scl_fall && s_q.phase == RTCW_WRITE_DATA && s_q.bit_cnt == 4'h9 &&
       !ev.start && !ev.stop) |=> s_q.ptr == $past(s_q.ptr) + 3'h1;
  endproperty
  a_write_ptr: assert property (p_write_ptr)
    else $error("write pointer did not advance");
  property p_read_advance;
    @(posedge clk) disable iff (!arst_n)
      (ev.scl_fall && s_q.phase == RTCW_READ_DATA && s_q.bit_cnt == 4'h8 &&
       !s_q.ack_nack) |=> s_q.ptr == $past(s_q.ptr) + 3'h1;
  endproperty
  a_read_advance: assert property (p_read_advance)
    else $error("read pointer did not advance on acknowledge");
  c_halted: cover property (@(posedge clk) s_q.regs[0][`RTCW_OSC_HALT_BIT]);
  c_write: cover property (@(posedge clk) s_q.load_strobe);
  c_read_ack: cover property (@(posedge clk)
    s_q.phase == RTCW_READ_DATA && ev.scl_fall && s_q.bit_cnt == 4'h8 &&
    !s_q.ack_nack);
  c_read_end: cover property (@(posedge clk) s_q.phase == RTCW_MASTER_ACK);
endmodule : rtcw_slave

// ### test/rtcw_master.sv
// Behavioural two-wire bus master for the clock register block
`timescale 1ns/10ps
module rtcw_master #(
  parameter int HALF = 6
)(
  input wire logic clk,
  input wire logic sda,
  output logic scl,
  output logic sda_pull
);
  // SDA is open drain, released means pulled high; SCL is driven directly
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  task automatic pause(input int n);
    repeat (n) @(posedge clk);
  endtask : pause
  // ****************************************************
  // Bus conditions
  // ****************************************************
  task automatic start();
    pause(HALF);
    sda_pull <= 1'b0;
    pause(HALF);
    scl <= 1'b1;
    pause(HALF);
    sda_pull <= 1'b1;
    pause(HALF);
    scl <= 1'b0;
  endtask : start
  task automatic stop();
    pause(HALF);
    sda_pull <= 1'b1;
    pause(HALF);
    scl <= 1'b1;
    pause(HALF);
    sda_pull <= 1'b0;
    pause(HALF);
  endtask : stop
  // Data moves mid-way through the low phase, clear of both clock edges
  task automatic bit_io(input logic b, output logic s);
    logic s1;
    pause(HALF / 2);
    sda_pull <= !b;
    pause(HALF - HALF / 2);
    scl <= 1'b1;
    pause(HALF / 2);
    s1 = sda;
    pause(HALF - HALF / 2);
    s = s1 | sda;
    scl <= 1'b0;
  endtask : bit_io
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], s);
    end
    bit_io(1'b1, s);
    ack = !s;
  endtask : wr_byte
  task automatic rd_byte(input logic ack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, s);
      d[i] = s;
    end
    bit_io(!ack, s);
  endtask : rd_byte
endmodule : rtcw_master

// ### test/tb_top.sv
// Self-checking bench for the two-wire clock register block
`timescale 1ns/10ps
`include "rtcw_defs.svh"
`define CHK(nm, exp, got) \
  begin \
    comparisons++; \
    if ((got) !== (exp)) begin \
      error_cnt++; \
      $display("BAD %s exp %0h got %0h", nm, exp, got); \
    end \
  end
module tb_top;
  localparam int TICK = 10;
  localparam int LIMIT = 20000;
  localparam logic [55:0] LIVE = 56'h24_C3_31_05_23_47_35;
  localparam logic [55:0] LIVE2 = 56'h25_C3_31_05_23_47_36;
  logic clk, arst_n, scl, sda_pull, sda_out, sda_oe;
  logic load_strobe, div_reset, osc_halt_bit, osc_fail_irq_enable;
  logic update_frozen, div_tick;
  logic [7:0] rate_trim;
  logic [55:0] live_time, load_time, last_load;
  wire sda_line;
  int error_cnt = 0;
  int comparisons = 0;
  int cyc = 0;
  int ticks = 0;
  int strobes = 0;
  assign sda_line = !(sda_pull || (sda_oe && !sda_out));
  rtcw_slave #(
    .DIV_TICK_CYC(TICK)
  ) i_rtcw_slave (
    .clk(clk),
    .arst_n(arst_n),
    .scl_in(scl),
    .sda_in(sda_line),
    .sda_out(sda_out),
    .sda_oe(sda_oe),
    .live_time(live_time),
    .load_time(load_time),
    .load_strobe(load_strobe),
    .div_reset(div_reset),
    .osc_halt_bit(osc_halt_bit),
    .osc_fail_irq_enable(osc_fail_irq_enable),
    .rate_trim(rate_trim),
    .update_frozen(update_frozen),
    .div_tick(div_tick)
  );
  rtcw_master m_bus (
    .clk(clk),
    .sda(sda_line),
    .scl(scl),
    .sda_pull(sda_pull)
  );
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic complete_run();
    if (error_cnt == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : complete_run
  // ****************************************************
  // Monitor and hang guard
  // ****************************************************
  always @(posedge clk) begin
    cyc++;
    if (div_tick === 1'b1) ticks++;
    if (load_strobe === 1'b1) begin
      strobes++;
      last_load = load_time;
      `CHK("div reset", 1'b1, div_reset)
    end
    if (cyc == LIMIT) begin
      error_cnt++;
      complete_run();
    end
  end
  task automatic wr_regs(input logic [2:0] ptr, input logic [15:0] data,
                         input int n);
    logic a;
    logic ok;
    ok = 1'b1;
    m_bus.start();
    m_bus.wr_byte(`RTCW_SLAVE_ADDR_BYTE, a);
    ok &= a;
    m_bus.wr_byte({5'h00, ptr}, a);
    ok &= a;
    for (int i = 0; i < n; i++) begin
      m_bus.wr_byte(data[15 - 8 * i -: 8], a);
      ok &= a;
    end
    m_bus.stop();
    `CHK("write acks", 1'b1, ok)
  endtask : wr_regs
  // ****************************************************
  // Test sequence
  // ****************************************************
  initial begin
    logic [7:0] d;
    logic a;
    int t0;
    arst_n = 1'b0;
    live_time = LIVE;
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    repeat (6) @(posedge clk);
    m_bus.start();
    m_bus.wr_byte(8'hA0, a);
    `CHK("foreign ack", 1'b0, a)
    m_bus.stop();
    t0 = strobes;
    wr_regs(3'h7, 16'hA500, 1);
    `CHK("trim", 8'hA5, rate_trim)
    `CHK("trim strobes", 0, strobes - t0)
    wr_regs(3'h0, 16'h9281, 2);
    `CHK("strobes", 2, strobes - t0)
    `CHK("halt", 1'b1, osc_halt_bit)
    `CHK("fail en", 1'b1, osc_fail_irq_enable)
    `CHK("load min", 8'h81, last_load[15:8])
    t0 = ticks;
    repeat (50) @(posedge clk);
    `CHK("halted ticks", 0, ticks - t0)
    m_bus.start();
    m_bus.wr_byte(`RTCW_SLAVE_ADDR_BYTE, a);
    m_bus.wr_byte(8'h06, a);
    m_bus.start();
    m_bus.wr_byte(`RTCW_SLAVE_ADDR_BYTE | 8'h01, a);
    m_bus.pause(6);
    `CHK("frozen", 1'b1, update_frozen)
    // Live time moves on; the frozen year copy must not follow it
    live_time <= LIVE2;
    m_bus.rd_byte(1'b1, d);
    `CHK("year", LIVE[55:48], d)
    m_bus.rd_byte(1'b1, d);
    `CHK("trim rd", 8'hA5, d)
    m_bus.rd_byte(1'b0, d);
    `CHK("wrap", {1'b1, LIVE2[6:0]}, d)
    m_bus.pause(6);
    `CHK("released", 1'b0, sda_oe)
    m_bus.stop();
    `CHK("unfrozen", 1'b0, update_frozen)
    // Pointer must not have moved on the refused last byte
    m_bus.start();
    m_bus.wr_byte(`RTCW_SLAVE_ADDR_BYTE | 8'h01, a);
    m_bus.rd_byte(1'b0, d);
    `CHK("alt read", {1'b1, LIVE2[6:0]}, d)
    m_bus.stop();
    wr_regs(3'h0, 16'h3500, 1);
    `CHK("run", 1'b0, osc_halt_bit)
    `CHK("load sec", 8'h35, last_load[7:0])
    t0 = ticks;
    repeat (100) @(posedge clk);
    `CHK("ticks", 1'b1, (ticks - t0) inside {[9:11]})
    `CHK("cmonth", LIVE2[47:40], load_time[47:40])
    `CHK("weekday", LIVE2[26:24], load_time[26:24])
    complete_run();
  end
endmodule : tb_top
